// [core/wlbc_top.sv]
// Notes on behaviour
// - run stage on: low request drives low relay, high request drives both relays.
// - intermittent request paces wipes from vehicle speed and interval setting.
// - washer press of 0.2 to 0.6 s gives one 0.7 s wipe after 0.3 s.
// - washer held past 0.6 s runs the wiper from 0.3 s after press.
// - after a held washer is released the wiper stops 3 s later.
// - run stage on and single_request_a input active hold the low relay on.
// - head lamp washer runs on its switch with tails, or washer with heads.
// - automatic request drives both wiper relays from the rain sensor.
// - entering automatic wipes once on rain; first entry since ignition always wipes.
// - automatic already selected at ignition on gives one wipe.
// - sensitivity increase with rain wipes once; repeats within 2 s add none.
// - internal fault held 1 s stops wipers; level 3 to 2 wipes once.
// - glass fault held 1 s stops wipers; level 4 to 3 wipes once.
// - no-signal code held 1 s or stuck duty held 2 s forces wipers off.
// - tails on, ignition off, then driver door opens: tails cut.
// - ignition on, driver door opens, then ignition off: tails cut.
// - cut cancelled by tail switch off then on, or key insertion.
// - first stage on and low beam switch turn the low beam relay on.
// - high request with low beam relay on drives high relay and indicator.
// - passing request drives both high and low beam relays.
// - auto light drives tail and low beam relays from light sensor levels.
// - bad sensor supply flags failure and, under auto light, keeps head lamps on.
`timescale 1ns/1ps
module wlbc_top #(
	parameter int TICK_CYCLES = wlbc_pkg::TICK_CYC
) (
	input  wire logic        CLK,
	input  wire logic        RSTN,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        IGNITION_RUN_STAGE,
	input  wire logic        IGNITION_FIRST_STAGE,
	input  wire logic        WIPER_LOW_REQ,
	input  wire logic        WIPER_HIGH_REQ,
	input  wire logic        WIPER_INT_REQ,
	input  wire logic        WIPER_AUTO_REQ,
	input  wire logic [2:0]  INT_SETTING,
	input  wire logic [7:0]  VEHICLE_SPEED,
	input  wire logic        WASHER_SW,
	input  wire logic        SINGLE_REQUEST_A,
	input  wire logic        HL_WASHER_SW,
	input  wire logic        TAIL_SW,
	input  wire logic        HEAD_LOW_SW,
	input  wire logic        HEAD_HIGH_SW,
	input  wire logic        PASSING_SW,
	input  wire logic        AUTO_LIGHT_SW,
	input  wire logic        DARK_TAIL,
	input  wire logic        DARK_HEAD,
	input  wire logic        SENSOR_SUPPLY_OK,
	input  wire logic [2:0]  SENSITIVITY,
	input  wire logic        RAIN_PWM,
	input  wire logic        DRIVER_DOOR,
	input  wire logic        KEY_IN,
	output logic             WIPER_LOW_RELAY,
	output logic             WIPER_HIGH_RELAY,
	output logic             HL_WASHER_OUT,
	output logic             TAIL_RELAY,
	output logic             LOW_BEAM_RELAY,
	output logic             HIGH_BEAM_RELAY,
	output logic             HIGH_BEAM_IND
);
	import wlbc_pkg::*;

	localparam int          SW        = 34;
	localparam logic [18:0] TICK_LAST = 19'(TICK_CYCLES - 1);

	typedef struct packed {
		logic        tick;
		logic [18:0] tick_cnt;
		wlbc_wash_t  wst;
		logic [8:0]  wcnt;
		logic [6:0]  wipe_cnt;
		logic [10:0] int_cnt;
		logic        auto_prev;
		logic        first_done;
		logic [2:0]  sens_prev;
		logic [7:0]  gap;
		logic [6:0]  fcnt;
		logic [2:0]  fcls;
		logic [1:0]  fault;
		logic        ignition_first_stage_prev;
		logic        door_prev;
		logic        key_prev;
		logic        tail_prev;
		logic        door_flag;
		logic        cut;
		logic        sup_fail;
		logic        wlo;
		logic        whi;
		logic        hlw;
		logic        tail;
		logic        low;
		logic        high;
		logic        ind;
		logic [7:0]  thr;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} wlbc_state_t;
	wlbc_state_t s, next_s;

	logic [SW-1:0] raw;
	logic [SW-1:0] syn;
	logic          ignition_run_stage;
	logic          ignition_first_stage;
	logic          wl;
	logic          wh;
	logic          wi;
	logic          wa;
	logic [2:0]    int_set;
	logic [7:0]    speed;
	logic          wash;
	logic          single_request_a;
	logic          hlw_sw;
	logic          tail_sw;
	logic          hlow;
	logic          hhigh;
	logic          pass;
	logic          autol;
	logic          dtail;
	logic          dhead;
	logic          supok;
	logic [2:0]    sens;
	logic          rain_pin;
	logic          door;
	logic          key;

	// all vehicle input pins pass the three-stage synchroniser; the apb pins do not
	assign raw = {IGNITION_RUN_STAGE, IGNITION_FIRST_STAGE, WIPER_LOW_REQ,
		WIPER_HIGH_REQ, WIPER_INT_REQ, WIPER_AUTO_REQ, INT_SETTING,
		VEHICLE_SPEED, WASHER_SW, SINGLE_REQUEST_A, HL_WASHER_SW, TAIL_SW,
		HEAD_LOW_SW, HEAD_HIGH_SW, PASSING_SW, AUTO_LIGHT_SW, DARK_TAIL,
		DARK_HEAD, SENSOR_SUPPLY_OK, SENSITIVITY, RAIN_PWM, DRIVER_DOOR, KEY_IN};
	assign {ignition_run_stage, ignition_first_stage, wl, wh, wi, wa, int_set, speed, wash, single_request_a, hlw_sw,
		tail_sw, hlow, hhigh, pass, autol, dtail, dhead, supok, sens,
		rain_pin, door, key} = syn;

	wlbc_sync #(.W(SW)) u_sync (
		.clk  (CLK),
		.rstn (RSTN),
		.d    (raw),
		.q    (syn)
	);

	wlbc_rain_if rif ();

	wlbc_rain u_rain (
		.clk  (CLK),
		.rstn (RSTN),
		.pin  (rain_pin),
		.rif  (rif)
	);

	assign rif.tick = s.tick;

	// a sensitivity step from one level to another
	function automatic logic step(input logic [2:0] prev, input logic [2:0] cur,
		input logic [2:0] from, input logic [2:0] to);
		return (prev == from) && (cur == to);
	endfunction

	// fault kind of a confirmed fault class
	function automatic logic [1:0] kind(input logic [2:0] c);
		if (c == CLS_F1)
			return FK_F1;
		else if (c == CLS_F2)
			return FK_F2;
		else
			return FK_F3;
	endfunction

	// next state of the whole block
	always_comb begin
		logic        tk;
		logic        wipe_req;
		logic [10:0] int_len;
		logic        auto_on;
		logic        entry;
		logic        inc;
		logic        rainy;
		logic        wash_on;
		logic        auto_lo;
		logic        auto_hi;
		logic        door_rise;
		logic        setup;
		logic        hit_c;
		logic        hit_s;
		logic [31:0] status;
		tk        = s.tick;
		wipe_req  = 1'b0;
		int_len   = ({8'h00, int_set} + 11'h001) * INT_STEP_T;
		auto_on   = ignition_run_stage & wa;
		entry     = auto_on & ~s.auto_prev;
		inc       = sens < s.sens_prev;
		rainy     = wlbc_is_rain(rif.cls);
		wash_on   = 1'b0;
		auto_lo   = 1'b0;
		auto_hi   = 1'b0;
		door_rise = door & ~s.door_prev;
		setup     = PSEL & ~PENABLE;
		hit_c     = PADDR == CTRL_ADDR;
		hit_s     = PADDR == STAT_ADDR;
		status    = '0;
		next_s    = s;

		// common time base
		next_s.tick = 1'b0;
		if (s.tick_cnt == TICK_LAST) begin
			next_s.tick_cnt = '0;
			next_s.tick     = 1'b1;
		end else begin
			next_s.tick_cnt = s.tick_cnt + 19'h00001;
		end

		// washer press timing
		unique case (s.wst)
			W_IDLE: begin
				if (wash) begin
					next_s.wst  = W_PRESS;
					next_s.wcnt = '0;
				end
			end
			W_PRESS: begin
				if (!wash)
					next_s.wst = (s.wcnt >= WASH_MIN_T) ? W_SHORT : W_IDLE;
				else if (tk && s.wcnt >= WASH_MAX_T)
					next_s.wst = W_HOLD;
				else if (tk)
					next_s.wcnt = s.wcnt + 9'h001;
			end
			W_SHORT: begin
				if (tk && s.wcnt >= WASH_END_T)
					next_s.wst = W_IDLE;
				else if (tk)
					next_s.wcnt = s.wcnt + 9'h001;
			end
			W_HOLD: begin
				if (!wash) begin
					next_s.wst  = W_AFTER;
					next_s.wcnt = '0;
				end
			end
			W_AFTER: begin
				if (wash)
					next_s.wst = W_HOLD;
				else if (tk && s.wcnt >= WASH_RUN_T)
					next_s.wst = W_IDLE;
				else if (tk)
					next_s.wcnt = s.wcnt + 9'h001;
			end
			default: next_s.wst = W_IDLE;
		endcase
		// wiper runs from 0.3 s after the press
		if ((s.wst == W_PRESS || s.wst == W_SHORT) && s.wcnt >= WASH_DLY_T)
			wash_on = 1'b1;
		if (s.wst == W_HOLD || s.wst == W_AFTER)
			wash_on = 1'b1;

		// intermittent pacing, halved above the speed threshold
		if (speed > s.thr)
			int_len = {1'b0, int_len[10:1]};
		if (ignition_run_stage && wi) begin
			if (tk && s.int_cnt >= int_len) begin
				next_s.int_cnt = '0;
				wipe_req       = 1'b1;
			end else if (tk) begin
				next_s.int_cnt = s.int_cnt + 11'h001;
			end
		end else begin
			next_s.int_cnt = '1;
		end

		// automatic entry; ignition off rearms the first-entry wipe
		next_s.auto_prev = auto_on;
		if (!ignition_run_stage)
			next_s.first_done = 1'b0;
		if (entry) begin
			next_s.first_done = 1'b1;
			if (!s.first_done || rainy)
				wipe_req = 1'b1;
		end

		// sensitivity increases, spaced by the 2 s gap timer
		next_s.sens_prev = sens;
		if (tk && s.gap != SENS_GAP_T)
			next_s.gap = s.gap + 8'h01;
		if (auto_on && inc) begin
			next_s.gap = '0;
			if (s.fault == FK_NONE && rainy && s.gap == SENS_GAP_T)
				wipe_req = 1'b1;
		end
		if (auto_on && s.fault == FK_F1 && step(s.sens_prev, sens, SENS_L3, SENS_L2))
			wipe_req = 1'b1;
		if (auto_on && s.fault == FK_F2 && step(s.sens_prev, sens, SENS_L4, SENS_L3))
			wipe_req = 1'b1;

		// rain sensor fault confirmation over 1 s of the same code
		if (!auto_on || !wlbc_is_fault(rif.cls)) begin
			next_s.fcnt  = '0;
			next_s.fcls  = rif.cls;
			next_s.fault = FK_NONE;
		end else if (rif.cls != s.fcls) begin
			next_s.fcnt = '0;
			next_s.fcls = rif.cls;
		end else if (tk && s.fcnt >= FAULT_T) begin
			next_s.fault = kind(rif.cls);
		end else if (tk) begin
			next_s.fcnt = s.fcnt + 7'h01;
		end

		// rain driven relays, off while a fault is confirmed
		if (auto_on && s.fault == FK_NONE) begin
			auto_lo = rainy;
			auto_hi = rif.cls == CLS_HEAVY;
		end

		// single wipe generator
		if (wipe_req && s.wipe_cnt == '0)
			next_s.wipe_cnt = WIPE_T;
		else if (tk && s.wipe_cnt != '0)
			next_s.wipe_cnt = s.wipe_cnt - 7'h01;

		// wiper relays
		next_s.wlo = ignition_run_stage & (wl | wh | single_request_a | wash_on | (s.wipe_cnt != '0) | auto_lo);
		next_s.whi = ignition_run_stage & (wh | auto_hi);

		// tail lamp auto cut
		next_s.ignition_first_stage_prev = ignition_first_stage;
		next_s.door_prev = door;
		next_s.key_prev  = key;
		next_s.tail_prev = tail_sw;
		if (ignition_first_stage && door_rise)
			next_s.door_flag = 1'b1;
		else if (!ignition_first_stage)
			next_s.door_flag = 1'b0;
		if (!ignition_first_stage && door_rise && tail_sw)
			next_s.cut = 1'b1;
		else if (!ignition_first_stage && s.ignition_first_stage_prev && s.door_flag)
			next_s.cut = 1'b1;
		else if ((key && !s.key_prev) || (tail_sw && !s.tail_prev))
			next_s.cut = 1'b0;

		// lamps
		next_s.sup_fail = ignition_first_stage & ~supok;
		next_s.tail = (tail_sw & ~s.cut) | (ignition_first_stage & autol & dtail);
		next_s.low  = ignition_first_stage & (hlow | pass | (autol & (dhead | s.sup_fail)));
		next_s.high = ignition_first_stage & ((hhigh & s.low) | pass);
		next_s.ind  = ignition_first_stage & ((hhigh & s.low) | pass);
		next_s.hlw  = ignition_run_stage & ((hlw_sw & s.tail) | (wash & s.low));

		// apb slave, answer in the first access cycle
		status[ST_WLO]            = s.wlo;
		status[ST_WHI]            = s.whi;
		status[ST_HLW]            = s.hlw;
		status[ST_TAIL]           = s.tail;
		status[ST_LOW]            = s.low;
		status[ST_HIGH]           = s.high;
		status[ST_CUT]            = s.cut;
		status[ST_SUPF]           = s.sup_fail;
		status[ST_CLS +: 3]       = rif.cls;
		status[ST_FLT +: 2]       = s.fault;
		status[ST_WST +: 5]       = s.wst;
		next_s.pready  = setup;
		next_s.pslverr = setup & ~(hit_c | hit_s);
		next_s.prdata  = '0;
		if (setup && hit_c)
			next_s.prdata = {24'h000000, s.thr};
		else if (setup && hit_s)
			next_s.prdata = status;
		if (PSEL && PENABLE && s.pready && PWRITE && hit_c)
			next_s.thr = PWDATA[7:0];
	end

	// state register
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			s         <= '0;
			s.wst     <= W_IDLE;
			s.gap     <= SENS_GAP_T;
			s.int_cnt <= '1;
			s.thr     <= CTRL_RST;
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from the state register
	assign PRDATA           = s.prdata;
	assign PREADY           = s.pready;
	assign PSLVERR          = s.pslverr;
	assign WIPER_LOW_RELAY  = s.wlo;
	assign WIPER_HIGH_RELAY = s.whi;
	assign HL_WASHER_OUT    = s.hlw;
	assign TAIL_RELAY       = s.tail;
	assign LOW_BEAM_RELAY   = s.low;
	assign HIGH_BEAM_RELAY  = s.high;
	assign HIGH_BEAM_IND    = s.ind;
endmodule // wlbc_top

// [pkg/wlbc_pkg.sv]
package wlbc_pkg;
	// time base
	localparam int CLK_HZ   = 50_000_000;
	localparam int TICK_MS  = 10;
	localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;

	// durations in ms, then in ticks
	localparam int WASH_MIN_MS = 200;
	localparam int WASH_MAX_MS = 600;
	localparam int WASH_DLY_MS = 300;
	localparam int WIPE_MS     = 700;
	localparam int WASH_RUN_MS = 3000;
	localparam int SENS_GAP_MS = 2000;
	localparam int FAULT_MS    = 1000;
	localparam int STUCK_MS    = 1000;
	localparam int INT_STEP_MS = 2000;
	localparam logic [8:0]  WASH_MIN_T = 9'(WASH_MIN_MS / TICK_MS);
	localparam logic [8:0]  WASH_MAX_T = 9'(WASH_MAX_MS / TICK_MS);
	localparam logic [8:0]  WASH_DLY_T = 9'(WASH_DLY_MS / TICK_MS);
	localparam logic [8:0]  WASH_END_T = 9'((WASH_DLY_MS + WIPE_MS) / TICK_MS);
	localparam logic [8:0]  WASH_RUN_T = 9'(WASH_RUN_MS / TICK_MS);
	localparam logic [6:0]  WIPE_T     = 7'(WIPE_MS / TICK_MS);
	localparam logic [7:0]  SENS_GAP_T = 8'(SENS_GAP_MS / TICK_MS);
	localparam logic [6:0]  FAULT_T    = 7'(FAULT_MS / TICK_MS);
	localparam logic [6:0]  STUCK_T    = 7'(STUCK_MS / TICK_MS);
	localparam logic [10:0] INT_STEP_T = 11'(INT_STEP_MS / TICK_MS);

	// register map
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] STAT_ADDR = 8'h04;
	localparam logic [7:0] CTRL_RST  = 8'h50;
	localparam int ST_WLO  = 0;
	localparam int ST_WHI  = 1;
	localparam int ST_HLW  = 2;
	localparam int ST_TAIL = 3;
	localparam int ST_LOW  = 4;
	localparam int ST_HIGH = 5;
	localparam int ST_CUT  = 6;
	localparam int ST_SUPF = 7;
	localparam int ST_CLS  = 8;
	localparam int ST_FLT  = 11;
	localparam int ST_WST  = 13;

	// rain sensor duty classes and band limits in percent
	localparam logic [2:0] CLS_DRY   = 3'h0;
	localparam logic [2:0] CLS_RAIN  = 3'h1;
	localparam logic [2:0] CLS_HEAVY = 3'h2;
	localparam logic [2:0] CLS_F1    = 3'h3;
	localparam logic [2:0] CLS_F2    = 3'h4;
	localparam logic [2:0] CLS_F3    = 3'h5;
	localparam logic [31:0] BAND_F1  = 32'h0000000f;
	localparam logic [31:0] BAND_F2  = 32'h00000019;
	localparam logic [31:0] BAND_F3  = 32'h00000023;
	localparam logic [31:0] BAND_DRY = 32'h0000003c;
	localparam logic [31:0] BAND_RN  = 32'h00000055;
	localparam logic [31:0] PCT      = 32'h00000064;

	// confirmed fault kinds and sensitivity levels
	localparam logic [1:0] FK_NONE = 2'h0;
	localparam logic [1:0] FK_F1   = 2'h1;
	localparam logic [1:0] FK_F2   = 2'h2;
	localparam logic [1:0] FK_F3   = 2'h3;
	localparam logic [2:0] SENS_L2 = 3'h2;
	localparam logic [2:0] SENS_L3 = 3'h3;
	localparam logic [2:0] SENS_L4 = 3'h4;

	typedef enum logic [4:0] {
		W_IDLE  = 5'h01,
		W_PRESS = 5'h02,
		W_SHORT = 5'h04,
		W_HOLD  = 5'h08,
		W_AFTER = 5'h10
	} wlbc_wash_t;

	function automatic logic wlbc_is_rain(input logic [2:0] c);
		return (c == CLS_RAIN) || (c == CLS_HEAVY);
	endfunction

	function automatic logic wlbc_is_fault(input logic [2:0] c);
		return (c == CLS_F1) || (c == CLS_F2) || (c == CLS_F3);
	endfunction
endpackage

// [pkg/wlbc_rain_if.sv]
`timescale 1ns/1ps
interface wlbc_rain_if;
	logic       tick;
	logic [2:0] cls;
	modport core (output tick, input cls);
	modport meas (input tick, output cls);
endinterface // wlbc_rain_if

// [core/wlbc_sync.sv]
`timescale 1ns/1ps
module wlbc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} wlbc_sync_t;
	wlbc_sync_t s, next_s;

	// three stages; a bit changes once stages two and three agree
	always_comb begin
		next_s    = s;
		next_s.s1 = d;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
		for (int i = 0; i < W; i++) begin
			if (s.s2[i] == s.s3[i])
				next_s.q[i] = s.s3[i];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			s <= '0;
		else
			s <= next_s;
	end

	assign q = s.q;
endmodule // wlbc_sync

// [core/wlbc_rain.sv]
`timescale 1ns/1ps
module wlbc_rain (
	input wire logic   clk,
	input wire logic   rstn,
	input wire logic   pin,
	wlbc_rain_if.meas  rif
);
	import wlbc_pkg::*;

	typedef struct packed {
		logic        prev;
		logic [23:0] hi;
		logic [23:0] per;
		logic [6:0]  idle;
		logic [2:0]  cls;
	} wlbc_rain_t;
	wlbc_rain_t s, next_s;

	// duty band of one pwm period, compared in percent without division
	function automatic logic [2:0] band(input logic [23:0] hi, input logic [23:0] per);
		logic [31:0] h;
		logic [31:0] p;
		h = {8'h00, hi} * PCT;
		p = {8'h00, per};
		if (h < p * BAND_F1)       return CLS_F1;
		else if (h < p * BAND_F2)  return CLS_F2;
		else if (h < p * BAND_F3)  return CLS_F3;
		else if (h < p * BAND_DRY) return CLS_DRY;
		else if (h < p * BAND_RN)  return CLS_RAIN;
		else                       return CLS_HEAVY;
	endfunction

	// measure high time and period, classify at each rising edge
	always_comb begin
		next_s      = s;
		next_s.prev = pin;
		if (s.per != '1)
			next_s.per = s.per + 24'h000001;
		if (pin && s.hi != '1)
			next_s.hi = s.hi + 24'h000001;
		if (rif.tick && s.idle != STUCK_T)
			next_s.idle = s.idle + 7'h01;
		if (pin && !s.prev) begin
			next_s.cls  = band(s.hi, s.per);
			next_s.hi   = '0;
			next_s.per  = '0;
			next_s.idle = '0;
		end else if (s.idle == STUCK_T) begin
			next_s.cls = CLS_F3;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			s <= '0;
		else
			s <= next_s;
	end

	assign rif.cls = s.cls;
endmodule // wlbc_rain

// [test/wlbc_asserts.sv]
`timescale 1ns/1ps
module wlbc_asserts #(
	parameter int TICK_CYCLES = 50
) (
	input wire logic        CLK,
	input wire logic        RSTN,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        IGNITION_RUN_STAGE,
	input wire logic        IGNITION_FIRST_STAGE,
	input wire logic        WIPER_LOW_REQ,
	input wire logic        WIPER_HIGH_REQ,
	input wire logic        WIPER_AUTO_REQ,
	input wire logic        SINGLE_REQUEST_A,
	input wire logic        PASSING_SW,
	input wire logic        WIPER_LOW_RELAY,
	input wire logic        WIPER_HIGH_RELAY,
	input wire logic        HL_WASHER_OUT,
	input wire logic        LOW_BEAM_RELAY,
	input wire logic        HIGH_BEAM_RELAY,
	input wire logic        HIGH_BEAM_IND
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	// held requests reach the relays once the synchroniser latency has passed
	a_low_only: assert property ((IGNITION_RUN_STAGE && WIPER_LOW_REQ && !WIPER_HIGH_REQ
		&& !WIPER_AUTO_REQ)[*8] |-> WIPER_LOW_RELAY && !WIPER_HIGH_RELAY)
		else $error("low request relays wrong");
	a_high_both: assert property ((IGNITION_RUN_STAGE && WIPER_HIGH_REQ)[*8]
		|-> WIPER_LOW_RELAY && WIPER_HIGH_RELAY) else $error("high request relays wrong");
	a_single_request_a_low: assert property ((IGNITION_RUN_STAGE && SINGLE_REQUEST_A)[*8]
		|-> WIPER_LOW_RELAY) else $error("single_request_a relay wrong");
	a_whi_pair: assert property (WIPER_HIGH_RELAY |-> WIPER_LOW_RELAY)
		else $error("high relay without low relay");
	a_hlw_run: assert property ((!IGNITION_RUN_STAGE)[*8] |-> !HL_WASHER_OUT)
		else $error("head lamp washer without run stage");
	a_hb_low: assert property ($rose(HIGH_BEAM_RELAY) |-> LOW_BEAM_RELAY)
		else $error("high beam without low beam");
	a_hb_ign: assert property ((!IGNITION_FIRST_STAGE)[*8]
		|-> !HIGH_BEAM_RELAY && !HIGH_BEAM_IND) else $error("high beam without stage");
	a_pass_both: assert property ((IGNITION_FIRST_STAGE && PASSING_SW)[*8]
		|-> HIGH_BEAM_RELAY && LOW_BEAM_RELAY) else $error("passing relays wrong");
	a_ind_follow: assert property (HIGH_BEAM_IND == HIGH_BEAM_RELAY)
		else $error("indicator differs from relay");
	// bus answer slot and error qualification
	a_ready_slot: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
		else $error("ready slot wrong");
	a_err_ready: assert property (PSLVERR |-> PREADY) else $error("error without ready");
	a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h00000000)
		else $error("read data outside answer");
endmodule // wlbc_asserts

bind wlbc_top wlbc_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_asserts (.*);

// [test/wlbc_rain_model.sv]
`timescale 1ns/1ps
module wlbc_rain_model #(
	parameter int PERIOD = 100
) (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic [6:0] duty,
	output logic            pwm
);
	logic [6:0] cnt;
	// duty frame in percent; 0 and 100 leave the line stuck
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt <= 7'h00;
			pwm <= 1'h0;
		end else begin
			cnt <= (cnt == 7'(PERIOD - 1)) ? 7'h00 : cnt + 7'h01;
			pwm <= (cnt < duty);
		end
	end
endmodule // wlbc_rain_model

// [test/wlbc_tb_top.sv]
`timescale 1ns/1ps
module wlbc_tb_top;
	import wlbc_pkg::*;
	localparam int TCK = 50; // one tick is 50 cycles
	logic CLK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
	logic [7:0] PADDR, VEHICLE_SPEED;
	logic [31:0] PWDATA, PRDATA, rd;
	logic IGNITION_RUN_STAGE, IGNITION_FIRST_STAGE, WIPER_LOW_REQ, WIPER_HIGH_REQ;
	logic WIPER_INT_REQ, WIPER_AUTO_REQ, WASHER_SW, SINGLE_REQUEST_A, HL_WASHER_SW, TAIL_SW;
	logic HEAD_LOW_SW, HEAD_HIGH_SW, PASSING_SW, AUTO_LIGHT_SW, DARK_TAIL, DARK_HEAD;
	logic SENSOR_SUPPLY_OK, RAIN_PWM, DRIVER_DOOR, KEY_IN, WIPER_LOW_RELAY, WIPER_HIGH_RELAY;
	logic HL_WASHER_OUT, TAIL_RELAY, LOW_BEAM_RELAY, HIGH_BEAM_RELAY, HIGH_BEAM_IND;
	logic [2:0] INT_SETTING, SENSITIVITY;
	logic [6:0] duty;
	int miscompares, cmp_count;
	// rows: run, ignition_first_stage, low, high, single_request_a, tail, hl washer, head low, head high, passing
	logic [9:0] row_in [11] = '{10'h280, 10'h240, 10'h080, 10'h220, 10'h218, 10'h208,
		10'h104, 10'h106, 10'h102, 10'h101, 10'h001};
	// relays: wiper low, wiper high, hl washer, tail, low beam, high beam, indicator
	logic [6:0] row_out [11] = '{7'h40, 7'h60, 7'h00, 7'h40, 7'h18, 7'h00,
		7'h04, 7'h07, 7'h00, 7'h07, 7'h00};

	wlbc_rain_model u_rain (.clk(CLK), .rstn(RSTN), .duty(duty), .pwm(RAIN_PWM));
	wlbc_top #(.TICK_CYCLES(TCK)) dut (.*);

	always #10 CLK = ~CLK;

	task automatic wt(input int n);
		repeat (n) @(posedge CLK);
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one transfer, started right after a rising edge; held until ready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'h2, wr, a, d};
		@(posedge CLK);
		PENABLE <= 1'h1;
		do @(posedge CLK); while (PREADY !== 1'h1);
		rd = PRDATA;
		err = PSLVERR;
		{PSEL, PENABLE} <= 2'h0;
		@(posedge CLK);
	endtask

	task automatic end_of_test;
		if (miscompares == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge CLK);
		miscompares++;
		end_of_test;
	end

	initial begin
		{CLK, RSTN, PSEL, PENABLE, PWRITE, PADDR, PWDATA, IGNITION_RUN_STAGE, IGNITION_FIRST_STAGE,
			WIPER_LOW_REQ, WIPER_HIGH_REQ, WIPER_INT_REQ, WIPER_AUTO_REQ, WASHER_SW,
			SINGLE_REQUEST_A, HL_WASHER_SW, TAIL_SW, HEAD_LOW_SW, HEAD_HIGH_SW, PASSING_SW,
			AUTO_LIGHT_SW, DARK_TAIL, DARK_HEAD, DRIVER_DOOR, KEY_IN, INT_SETTING,
			SENSITIVITY, VEHICLE_SPEED} = '0;
		SENSOR_SUPPLY_OK = 1'h1;
		duty = 7'h32;
		wt(10);
		RSTN <= 1'h1;
		wt(2);
		chk("reset outputs", {PREADY, PSLVERR, WIPER_LOW_RELAY, WIPER_HIGH_RELAY, HL_WASHER_OUT,
			TAIL_RELAY, LOW_BEAM_RELAY, HIGH_BEAM_RELAY, HIGH_BEAM_IND}, 32'h0);
		// registers
		apb(1'h0, CTRL_ADDR, 32'h0);
		chk("ctrl reset", rd, 32'(CTRL_RST));
		apb(1'h1, CTRL_ADDR, 32'hffffff23);
		apb(1'h0, CTRL_ADDR, 32'h0);
		chk("ctrl", rd, 32'h00000023);
		apb(1'h1, STAT_ADDR, 32'hffffffff);
		chk("status write err", err, 1'h0);
		// the first rain period after reset is partial; let a full one be classed
		wt(100);
		apb(1'h0, STAT_ADDR, 32'h0);
		chk("status", rd, 32'h00000001 << ST_WST);
		apb(1'h0, 8'h08, 32'h0);
		chk("unmapped err", err, 1'h1);
		chk("unmapped data", rd, 32'h0);
		// plain relay cases
		for (int i = 0; i < 11; i++) begin
			{IGNITION_RUN_STAGE, IGNITION_FIRST_STAGE, WIPER_LOW_REQ, WIPER_HIGH_REQ,
				SINGLE_REQUEST_A, TAIL_SW, HL_WASHER_SW, HEAD_LOW_SW, HEAD_HIGH_SW,
				PASSING_SW} <= row_in[i];
			wt(12);
			chk("relays", {WIPER_LOW_RELAY, WIPER_HIGH_RELAY, HL_WASHER_OUT, TAIL_RELAY,
				LOW_BEAM_RELAY, HIGH_BEAM_RELAY, HIGH_BEAM_IND}, 32'(row_out[i]));
		end
		{IGNITION_FIRST_STAGE, PASSING_SW, TAIL_SW} <= 3'h5;
		wt(12);
		// tail cut, both orders, and both cancels
		IGNITION_FIRST_STAGE <= 1'h0;
		wt(12);
		DRIVER_DOOR <= 1'h1;
		wt(12);
		chk("tail cut", TAIL_RELAY, 1'h0);
		KEY_IN <= 1'h1;
		wt(12);
		chk("tail key", TAIL_RELAY, 1'h1);
		{IGNITION_FIRST_STAGE, DRIVER_DOOR, KEY_IN} <= 3'h4;
		wt(12);
		DRIVER_DOOR <= 1'h1;
		wt(12);
		IGNITION_FIRST_STAGE <= 1'h0;
		wt(12);
		chk("tail cut door first", TAIL_RELAY, 1'h0);
		TAIL_SW <= 1'h0;
		wt(12);
		TAIL_SW <= 1'h1;
		wt(12);
		chk("tail cycled", TAIL_RELAY, 1'h1);
		// auto light and supply failure
		{IGNITION_FIRST_STAGE, AUTO_LIGHT_SW, DARK_TAIL, TAIL_SW, DRIVER_DOOR} <= 5'h1c;
		wt(12);
		chk("auto tail", {TAIL_RELAY, LOW_BEAM_RELAY}, 2'h2);
		DARK_HEAD <= 1'h1;
		wt(12);
		chk("auto head", {TAIL_RELAY, LOW_BEAM_RELAY}, 2'h3);
		{DARK_TAIL, DARK_HEAD, SENSOR_SUPPLY_OK} <= 3'h0;
		wt(12);
		chk("supply fail", LOW_BEAM_RELAY, 1'h1);
		{AUTO_LIGHT_SW, SENSOR_SUPPLY_OK, IGNITION_RUN_STAGE} <= 3'h3;
		wt(12);
		// washer short press of 0.4 s
		WASHER_SW <= 1'h1;
		wt(25 * TCK);
		chk("wash delay", WIPER_LOW_RELAY, 1'h0);
		wt(15 * TCK);
		WASHER_SW <= 1'h0;
		wt(10 * TCK);
		chk("wash wipe", WIPER_LOW_RELAY, 1'h1);
		wt(70 * TCK);
		chk("wash end", WIPER_LOW_RELAY, 1'h0);
		// held press with head lamps on
		{HEAD_LOW_SW, WASHER_SW} <= 2'h3;
		wt(50 * TCK);
		chk("held run", WIPER_LOW_RELAY, 1'h1);
		chk("hl washer", HL_WASHER_OUT, 1'h1);
		wt(50 * TCK);
		{HEAD_LOW_SW, WASHER_SW, IGNITION_FIRST_STAGE} <= 3'h0;
		wt(260 * TCK);
		chk("run on", WIPER_LOW_RELAY, 1'h1);
		wt(80 * TCK);
		chk("run on end", WIPER_LOW_RELAY, 1'h0);
		// intermittent, interval halved above the speed threshold
		{WIPER_INT_REQ, VEHICLE_SPEED} <= 9'h140;
		wt(10 * TCK);
		chk("int first", WIPER_LOW_RELAY, 1'h1);
		wt(80 * TCK);
		chk("int gap", WIPER_LOW_RELAY, 1'h0);
		wt(15 * TCK);
		chk("int fast", WIPER_LOW_RELAY, 1'h1);
		WIPER_INT_REQ <= 1'h0;
		wt(70 * TCK);
		// automatic mode: first entry, heavy rain, stuck line
		WIPER_AUTO_REQ <= 1'h1;
		wt(10 * TCK);
		chk("auto entry", {WIPER_LOW_RELAY, WIPER_HIGH_RELAY}, 2'h2);
		wt(80 * TCK);
		chk("auto dry", {WIPER_LOW_RELAY, WIPER_HIGH_RELAY}, 2'h0);
		duty <= 7'h5a;
		wt(10 * TCK);
		chk("auto heavy", {WIPER_LOW_RELAY, WIPER_HIGH_RELAY}, 2'h3);
		duty <= 7'h00;
		wt(220 * TCK);
		chk("stuck fault", {WIPER_LOW_RELAY, WIPER_HIGH_RELAY}, 2'h0);
		apb(1'h0, STAT_ADDR, 32'h0);
		chk("stuck kind", rd[ST_CLS +: 5], {FK_F3, CLS_F3});
		// internal fault: a step from level 3 to 2 gives one wipe
		{SENSITIVITY, duty} <= {3'h3, 7'h0a};
		wt(120 * TCK);
		apb(1'h0, STAT_ADDR, 32'h0);
		chk("internal kind", rd[ST_FLT +: 2], FK_F1);
		SENSITIVITY <= 3'h2;
		wt(5 * TCK);
		chk("fault wipe", WIPER_LOW_RELAY, 1'h1);
		end_of_test;
	end
endmodule // wlbc_tb_top
